// [design/csm_recessive_counter.sv]
// Purpose: Count consecutive recessive bits on the CAN bus
// Assumes: bit_tick_i pulses once per sampled bit
// Notes:   done_o holds at the target while counting until a sampled dominant bit clears the count
`timescale 1ns/1ns
`default_nettype none
module csm_recessive_counter #(
  parameter int TARGET = csm_pkg::RECESSIVE_BITS,
  parameter int CW     = csm_pkg::RCNT_W
) (
  input  wire logic mclk_i,     // Clock
  input  wire logic sys_rst_i,  // Sync reset
  input  wire logic run_i,      // Count while high
  input  wire logic bit_tick_i, // Bit sample pulse
  input  wire logic rx_bit_i,   // Sampled bus level, 1 recessive
  output logic      done_o      // Target reached
);

  logic [CW-1:0] cnt_q;

  // ==========================================================
  // Counter
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !run_i) begin
      cnt_q <= '0;
    end else if (bit_tick_i) begin
      if (!rx_bit_i) begin
        cnt_q <= '0;
      end else if (cnt_q != CW'(TARGET)) begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end

  assign done_o = (cnt_q == CW'(TARGET));

endmodule : csm_recessive_counter
`default_nettype wire

// [design/csm_state_flags.sv]
// Purpose: CAN controller working-mode handshake and state flags
// Assumes: Avalon-MM slave, 32-bit, byte addresses; link status inputs synchronous
// Notes:   One wait cycle, then read/write answer; unmapped reads return zero
//
// Implementation choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
// Operation
// RQ1: Receive-active bit follows receiving state
// RQ2: Transmit-active bit 8 follows transmitting state
// RQ3: Sleep-entry flag set on sleep, auto-cleared, W1C
// RQ4: Wakeup flag set on bus activity asleep
// RQ5: Wakeup flag cleared by writing one
// RQ6: Error flag on bus-off with enable
// RQ7: Error flag on passive error with enable
// RQ8: Error flag on warning with enable
// RQ9: Error flag on codes 1..6 with enable
// RQ10: Error flag stays until written one
// RQ11: Sleep-state bit set once asleep
// RQ12: Sleep entry waits for frame end
// RQ13: Sleep-state cleared on leaving sleep
// RQ14: Leaving sleep needs 11 recessive bits
// RQ15: Init-state bit set once in init
// RQ16: Init entry waits for frame end
// RQ17: Init-state cleared when init withdrawn
// RQ18: Leaving init needs 11 recessive bits
// RQ19: Software keeps reserved bits 7:5 zero
// RQ20: Auto wakeup clears sleep request bit
// RQ21: Zero writes and read-only bits ignored
module csm_state_flags (
  input  wire logic                 mclk_i,              // Clock, 20 MHz
  input  wire logic                 sys_rst_i,           // Sync reset, high
  input  wire logic [3:0]           avs_address_i,       // Byte address
  input  wire logic                 avs_read_i,          // Read strobe
  input  wire logic                 avs_write_i,         // Write strobe
  input  wire logic [31:0]          avs_writedata_i,     // Write data
  input  wire logic [3:0]           avs_byteenable_i,    // Byte enables
  output logic [31:0]               avs_readdata_o,      // Read data
  output logic                      avs_waitrequest_o,   // Stall
  input  wire csm_pkg::csm_link_t   link_i,              // Bus activity view
  input  wire csm_pkg::csm_err_t    err_i,               // Error status
  output logic                      sleep_state_o,       // In sleep mode
  output logic                      init_state_o         // In init mode
);

  csm_pkg::csm_mode_t mode_q;
  logic [31:0]        ctrl_q;
  logic [31:0]        err_en_q;
  logic               sleep_entry_event_q;
  logic               wakeup_event_q;
  logic               error_event_q;
  logic               ack_q;
  logic [31:0]        rdata_q;
  logic               rec_run;
  logic               rec_done;
  logic               busy;
  logic               wr_acc;
  logic               rd_cap;
  logic               was_sleep_q;
  logic [31:0]        stat_w;
  logic               wr_stat;
  logic               clr_slp;
  logic               clr_wake;
  logic               clr_err;
  logic               err_hit;
  logic               auto_wake;
  logic [31:0]        wmask;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    return a == ofs;
  endfunction : hit

  function automatic logic w1c(input logic [31:0] wd, input logic [31:0] m, input int b);
    return wd[b] & m[b];
  endfunction : w1c

  // ==========================================================
  // Avalon-MM handshake: one wait cycle, then ack
  assign wr_acc            = avs_write_i && ack_q;
  assign rd_cap            = avs_read_i && !ack_q; // Read data captured in the wait cycle
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
  assign wmask             = be_mask(avs_byteenable_i);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_i || avs_write_i) && !ack_q;
    end
  end

  assign busy      = link_i.transmit_active || link_i.receive_active;
  assign auto_wake = ctrl_q[csm_pkg::AUTO_WAKE_BIT] && link_i.bus_activity;
  assign rec_run   = (mode_q == csm_pkg::CSM_WAKE_SYNC) || (mode_q == csm_pkg::CSM_INIT_SYNC);

  // ==========================================================
  // Recessive bit counter for mode exit
  csm_recessive_counter #(
    .TARGET (csm_pkg::RECESSIVE_BITS),
    .CW     (csm_pkg::RCNT_W)
  ) u_rec (
    .mclk_i     (mclk_i),
    .sys_rst_i  (sys_rst_i),
    .run_i      (rec_run),
    .bit_tick_i (link_i.bit_tick),
    .rx_bit_i   (link_i.rx_bit),
    .done_o     (rec_done)
  );

  // ==========================================================
  // Mode control register
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ctrl_q <= csm_pkg::MODE_CTRL_RST;
    end else begin
      if (wr_acc && hit(avs_address_i, csm_pkg::MODE_CTRL_OFS)) begin
        ctrl_q <= (ctrl_q & ~wmask) | (avs_writedata_i & wmask);
      end
      if (mode_q == csm_pkg::CSM_SLEEP && auto_wake) begin
        ctrl_q[csm_pkg::SLEEP_REQ_BIT] <= 1'b0; // RQ20
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      err_en_q <= csm_pkg::ERR_SRC_RST;
    end else if (wr_acc && hit(avs_address_i, csm_pkg::ERR_SRC_OFS)) begin
      err_en_q <= (err_en_q & ~wmask) | (avs_writedata_i & wmask);
    end
  end

  // ==========================================================
  // Working-mode sequencer; starts asleep like the control reset
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      mode_q <= csm_pkg::CSM_SLEEP;
    end else begin
      case (mode_q)
        csm_pkg::CSM_NORMAL: begin
          if (ctrl_q[csm_pkg::INIT_REQ_BIT]) begin
            mode_q <= busy ? csm_pkg::CSM_GO_INIT : csm_pkg::CSM_INIT; // RQ16
          end else if (ctrl_q[csm_pkg::SLEEP_REQ_BIT]) begin
            mode_q <= busy ? csm_pkg::CSM_GO_SLEEP : csm_pkg::CSM_SLEEP; // RQ12
          end
        end
        csm_pkg::CSM_GO_SLEEP: begin
          if (!ctrl_q[csm_pkg::SLEEP_REQ_BIT]) begin
            mode_q <= csm_pkg::CSM_NORMAL;
          end else if (!busy) begin
            mode_q <= csm_pkg::CSM_SLEEP; // RQ12
          end
        end
        csm_pkg::CSM_SLEEP: begin
          if (ctrl_q[csm_pkg::INIT_REQ_BIT]) begin
            mode_q <= csm_pkg::CSM_INIT;
          end else if (!ctrl_q[csm_pkg::SLEEP_REQ_BIT] || auto_wake) begin
            mode_q <= csm_pkg::CSM_WAKE_SYNC; // RQ13
          end
        end
        csm_pkg::CSM_WAKE_SYNC: begin
          if (ctrl_q[csm_pkg::INIT_REQ_BIT]) begin
            mode_q <= csm_pkg::CSM_INIT;
          end else if (rec_done) begin
            mode_q <= csm_pkg::CSM_NORMAL; // RQ14
          end
        end
        csm_pkg::CSM_GO_INIT: begin
          if (!ctrl_q[csm_pkg::INIT_REQ_BIT]) begin
            mode_q <= csm_pkg::CSM_NORMAL;
          end else if (!busy) begin
            mode_q <= csm_pkg::CSM_INIT; // RQ16
          end
        end
        csm_pkg::CSM_INIT: begin
          if (!ctrl_q[csm_pkg::INIT_REQ_BIT]) begin
            mode_q <= ctrl_q[csm_pkg::SLEEP_REQ_BIT] ? csm_pkg::CSM_SLEEP
                                                     : csm_pkg::CSM_INIT_SYNC; // RQ17
          end
        end
        csm_pkg::CSM_INIT_SYNC: begin
          if (ctrl_q[csm_pkg::INIT_REQ_BIT]) begin
            mode_q <= csm_pkg::CSM_INIT;
          end else if (rec_done) begin
            mode_q <= csm_pkg::CSM_NORMAL; // RQ18
          end
        end
        default: begin
          mode_q <= csm_pkg::CSM_SLEEP;
        end
      endcase
    end
  end

  // Sleep and init indicators stay set through the exit sync
  assign sleep_state_o = (mode_q == csm_pkg::CSM_SLEEP) || (mode_q == csm_pkg::CSM_WAKE_SYNC); // RQ11 RQ13 RQ14
  assign init_state_o  = (mode_q == csm_pkg::CSM_INIT) || (mode_q == csm_pkg::CSM_INIT_SYNC);  // RQ15 RQ17 RQ18

  // ==========================================================
  // Event flags; hardware set wins over software clear
  assign wr_stat  = wr_acc && hit(avs_address_i, csm_pkg::STATE_FLAGS_OFS);
  assign clr_slp  = wr_stat && w1c(avs_writedata_i, wmask, csm_pkg::SLEEP_ENTRY_BIT);  // RQ21
  assign clr_wake = wr_stat && w1c(avs_writedata_i, wmask, csm_pkg::WAKEUP_EVENT_BIT); // RQ21
  assign clr_err  = wr_stat && w1c(avs_writedata_i, wmask, csm_pkg::ERROR_EVENT_BIT);  // RQ21

  // Previous-cycle sleep marker; reset matches the asleep reset state
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      was_sleep_q <= 1'b1;
    end else begin
      was_sleep_q <= (mode_q == csm_pkg::CSM_SLEEP);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sleep_entry_event_q <= 1'b0;
    end else if (!sleep_state_o) begin
      sleep_entry_event_q <= 1'b0; // RQ3
    end else if (mode_q == csm_pkg::CSM_SLEEP && !was_sleep_q) begin
      sleep_entry_event_q <= 1'b1; // RQ3
    end else if (clr_slp) begin
      sleep_entry_event_q <= 1'b0; // RQ3 RQ21
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wakeup_event_q <= 1'b0;
    end else if (mode_q == csm_pkg::CSM_SLEEP && link_i.bus_activity) begin
      wakeup_event_q <= 1'b1; // RQ4
    end else if (clr_wake) begin
      wakeup_event_q <= 1'b0; // RQ5 RQ21
    end
  end

  assign err_hit =
      (err_i.bus_off_status && err_en_q[csm_pkg::BUS_OFF_IE_BIT])          // RQ6
   || (err_i.passive_error_status && err_en_q[csm_pkg::PASSIVE_IE_BIT])    // RQ7
   || (err_i.warning_error_status && err_en_q[csm_pkg::WARN_IE_BIT])       // RQ8
   || (err_i.last_error_code >= csm_pkg::ERR_CODE_MIN
       && err_i.last_error_code <= csm_pkg::ERR_CODE_MAX
       && err_en_q[csm_pkg::ERR_CODE_IE_BIT]);                             // RQ9

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      error_event_q <= 1'b0;
    end else if (err_hit) begin
      error_event_q <= 1'b1; // RQ6 RQ7 RQ8 RQ9
    end else if (clr_err) begin
      error_event_q <= 1'b0; // RQ10 RQ21
    end
  end

  // ==========================================================
  // Status word; reserved bits 7:5 and upper bits read zero
  always_comb begin
    stat_w                             = 32'h0000_0000;
    stat_w[csm_pkg::RX_ACTIVE_BIT]     = link_i.receive_active;  // RQ1
    stat_w[csm_pkg::TX_ACTIVE_BIT]     = link_i.transmit_active; // RQ2
    stat_w[csm_pkg::SLEEP_ENTRY_BIT]   = sleep_entry_event_q;
    stat_w[csm_pkg::WAKEUP_EVENT_BIT]  = wakeup_event_q;
    stat_w[csm_pkg::ERROR_EVENT_BIT]   = error_event_q;
    stat_w[csm_pkg::SLEEP_STATE_BIT]   = sleep_state_o;
    stat_w[csm_pkg::INIT_STATE_BIT]    = init_state_o;
  end

  // ==========================================================
  // Read path; captured in the wait cycle, stands in the ack cycle
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_cap) begin
      case (avs_address_i)
        csm_pkg::STATE_FLAGS_OFS: begin
          rdata_q <= stat_w;
        end
        csm_pkg::MODE_CTRL_OFS: begin
          rdata_q <= ctrl_q;
        end
        csm_pkg::ERR_SRC_OFS: begin
          rdata_q <= err_en_q;
        end
        default: begin
          rdata_q <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Read data straight from the capture flop
  assign avs_readdata_o = rdata_q;

endmodule : csm_state_flags
`default_nettype wire

// [include/csm_pkg.sv]
// Purpose: Shared constants and types for the CAN state-flag block
// Assumes: 32-bit Avalon-MM register access, byte addresses on word boundaries
// Notes:   Offsets are byte addresses of aligned words
package csm_pkg;

  // ==========================================================
  // Register map
  localparam logic [3:0] STATE_FLAGS_OFS = 4'h0;
  localparam logic [3:0] MODE_CTRL_OFS   = 4'h4;
  localparam logic [3:0] ERR_SRC_OFS     = 4'h8;

  // ==========================================================
  // State-flag register fields
  localparam int INIT_STATE_BIT   = 0;
  localparam int SLEEP_STATE_BIT  = 1;
  localparam int ERROR_EVENT_BIT  = 2;
  localparam int WAKEUP_EVENT_BIT = 3;
  localparam int SLEEP_ENTRY_BIT  = 4;
  localparam int TX_ACTIVE_BIT    = 8;
  localparam int RX_ACTIVE_BIT    = 9;

  // ==========================================================
  // Mode control fields
  localparam int INIT_REQ_BIT   = 0;
  localparam int SLEEP_REQ_BIT  = 1;
  localparam int AUTO_WAKE_BIT  = 5;

  // ==========================================================
  // Error-source enable fields
  localparam int WARN_IE_BIT    = 0;
  localparam int PASSIVE_IE_BIT = 1;
  localparam int BUS_OFF_IE_BIT = 2;
  localparam int ERR_CODE_IE_BIT = 4;

  // ==========================================================
  // Reset values
  localparam logic [31:0] MODE_CTRL_RST = 32'h0000_0002;
  localparam logic [31:0] ERR_SRC_RST   = 32'h0000_0000;

  // ==========================================================
  // Timing
  localparam int RECESSIVE_BITS = 11;
  localparam int RCNT_W         = 4;

  // Last-error-code limits
  localparam logic [2:0] ERR_CODE_MIN = 3'h1;
  localparam logic [2:0] ERR_CODE_MAX = 3'h6;

  typedef enum logic [2:0] {
    CSM_NORMAL,
    CSM_GO_SLEEP,
    CSM_SLEEP,
    CSM_WAKE_SYNC,
    CSM_GO_INIT,
    CSM_INIT,
    CSM_INIT_SYNC
  } csm_mode_t;

  typedef struct packed {
    logic       bus_off_status;
    logic       passive_error_status;
    logic       warning_error_status;
    logic [2:0] last_error_code;
  } csm_err_t;

  typedef struct packed {
    logic rx_bit;
    logic bit_tick;
    logic transmit_active;
    logic receive_active;
    logic bus_activity;
  } csm_link_t;

endpackage : csm_pkg

// [tb/csm_bus_mdl.sv]
// Purpose: CAN bus side model feeding the link view
// Assumes: one bus bit lasts four clocks
// Notes:   Idle bus is recessive; frames toggle every bit
`timescale 1ns/1ns
`default_nettype none
module csm_bus_mdl (
  input  wire logic                mclk_i,    // Clock
  input  wire logic                sys_rst_i, // Sync reset
  input  wire logic                rxf_i,     // Frame being received
  input  wire logic                txf_i,     // Frame being sent
  input  wire logic                dom_i,     // Force dominant level
  output wire csm_pkg::csm_link_t  link_o     // Link view
);
  logic [1:0] div_q;
  logic       tgl_q;
  logic       lvl;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      div_q <= 2'h0;
      tgl_q <= 1'h0;
    end else begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) begin
        tgl_q <= ~tgl_q;
      end
    end
  end
  assign lvl = ~dom_i & ~((rxf_i | txf_i) & tgl_q);
  assign link_o = '{rx_bit: lvl, bit_tick: (div_q == 2'h3), transmit_active: txf_i,
                    receive_active: rxf_i, bus_activity: ~lvl};
endmodule : csm_bus_mdl
`default_nettype wire

// [tb/csm_state_flags_chk.sv]
// Purpose: Port-level assertions for the state-flag block
// Assumes: link inputs held stable around status reads
// Notes:   Recessive count is a superset of the design's count
`timescale 1ns/1ns
`default_nettype none
module csm_state_flags_chk (
  input wire logic                mclk_i,            // Clock
  input wire logic                sys_rst_i,         // Sync reset
  input wire logic [3:0]          avs_address_i,     // Byte address
  input wire logic                avs_read_i,        // Read strobe
  input wire logic                avs_waitrequest_o, // Stall
  input wire logic [31:0]         avs_readdata_o,    // Read data
  input wire csm_pkg::csm_link_t  link_i,            // Link view
  input wire logic                sleep_state_o,     // Asleep
  input wire logic                init_state_o       // In init
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  logic [3:0] rec_q;
  logic       rd0;
  assign rd0 = avs_read_i & ~avs_waitrequest_o & (avs_address_i == csm_pkg::STATE_FLAGS_OFS);
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i | (link_i.bit_tick & ~link_i.rx_bit)) begin
      rec_q <= 4'h0;
    end else if (link_i.bit_tick & (rec_q != 4'hF)) begin
      rec_q <= rec_q + 4'h1;
    end
  end
  rx_state_a: assert property (rd0 && $stable(link_i.receive_active)
    |-> avs_readdata_o[csm_pkg::RX_ACTIVE_BIT] == link_i.receive_active) else $error("receive bit wrong");
  tx_state_a: assert property (rd0 && $stable(link_i.transmit_active)
    |-> avs_readdata_o[csm_pkg::TX_ACTIVE_BIT] == link_i.transmit_active) else $error("transmit bit wrong");
  sleep_bit_a: assert property (rd0 && $stable(sleep_state_o)
    |-> avs_readdata_o[csm_pkg::SLEEP_STATE_BIT] == sleep_state_o) else $error("sleep bit wrong");
  init_bit_a: assert property (rd0 && $stable(init_state_o)
    |-> avs_readdata_o[csm_pkg::INIT_STATE_BIT] == init_state_o) else $error("init bit wrong");
  sleep_defer_a: assert property ($rose(sleep_state_o)
    |-> !$past(link_i.receive_active) && !$past(link_i.transmit_active)) else $error("sleep during frame");
  init_defer_a: assert property ($rose(init_state_o)
    |-> !$past(link_i.receive_active) && !$past(link_i.transmit_active)) else $error("init during frame");
  sleep_exit_a: assert property ($fell(sleep_state_o) && !init_state_o
    |-> rec_q >= 4'hB) else $error("sleep left too early");
  init_exit_a: assert property ($fell(init_state_o) && !sleep_state_o
    |-> rec_q >= 4'hB) else $error("init left too early");
endmodule : csm_state_flags_chk
`default_nettype wire

// [tb/tb.sv]
// Purpose: Self-checking bench for the state-flag block
// Assumes: bus model supplies link view; bench drives errors
// Notes:   Reads note expectations in a queue; a monitor compares
`timescale 1ns/1ns
`default_nettype none
module tb;
  typedef struct {string nm; logic [31:0] msk; logic [31:0] exp;} csm_exp_t;
  logic               mclk_i = 1'h0, sys_rst_i = 1'h1, rd = 1'h0, wr = 1'h0, rxf = 1'h0, txf = 1'h0, dom = 1'h0;
  logic [3:0]         adr = 4'h0, be = 4'hF;
  logic [31:0]        wd = 32'h0, rdat, seed = 32'h2de49d1d;
  logic               wt, slp, ini, ef;
  csm_pkg::csm_err_t  err = '0;
  csm_pkg::csm_link_t lnk;
  int                 err_count = 0, n_checks = 0, k;
  csm_exp_t           exp_q[$], it;
  csm_state_flags dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .link_i(lnk), .err_i(err), .sleep_state_o(slp), .init_state_o(ini));
  csm_bus_mdl u_bus (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .rxf_i(rxf), .txf_i(txf), .dom_i(dom), .link_o(lnk));
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : idle
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk_i);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk_i);
      if (wt === 1'h0) break;
    end
    if (i == 20) begin
      check("waitrequest", 32'h1, 32'h0);
      results();
    end
    rd <= 1'h0;
    wr <= 1'h0;
  endtask : bus
  task automatic rdx(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    exp_q.push_back('{nm, m, e});
    bus(1'h0, a, 32'h0);
  endtask : rdx
  task automatic wait_for(input logic want, input logic sel);
    int i;
    for (i = 0; i < 400; i++) begin
      @(negedge mclk_i);
      if ((sel ? slp : ini) === want) break;
    end
    check(sel ? "sleep_state" : "init_state", {31'h0, sel ? slp : ini}, {31'h0, want});
    if (i == 400) results();
  endtask : wait_for
  always @(posedge mclk_i) begin
    if (rd === 1'h1 && wt === 1'h0) begin
      it = exp_q.pop_front();
      check(it.nm, rdat & it.msk, it.exp);
    end
  end
  // ==========================================================
  // Scenarios
  initial begin
    idle(16);
    sys_rst_i <= 1'h0;
    rdx(csm_pkg::MODE_CTRL_OFS, 32'hFFFFFFFF, csm_pkg::MODE_CTRL_RST, "mode_rst");
    rdx(csm_pkg::ERR_SRC_OFS, 32'hFFFFFFFF, csm_pkg::ERR_SRC_RST, "err_src_rst");
    rdx(4'hC, 32'hFFFFFFFF, 32'h0, "unmapped");
    bus(1'h1, csm_pkg::STATE_FLAGS_OFS, 32'h303);
    rdx(csm_pkg::STATE_FLAGS_OFS, 32'h303, 32'h2, "read_only");
    $display("test reset done");
    bus(1'h1, csm_pkg::MODE_CTRL_OFS, 32'h0);
    idle(24);
    dom <= 1'h1;
    idle(4);
    dom <= 1'h0;
    wait_for(1'h0, 1'h1);
    rdx(csm_pkg::STATE_FLAGS_OFS, 32'h17, 32'h0, "left_sleep");
    bus(1'h1, csm_pkg::STATE_FLAGS_OFS, 32'h8);
    $display("test wake done");
    for (k = 0; k < 4; k++) begin
      rxf <= k[0];
      txf <= k[1];
      idle(2);
      rdx(csm_pkg::STATE_FLAGS_OFS, 32'h300, {22'h0, k[0], k[1], 8'h0}, "activity");
    end
    bus(1'h1, csm_pkg::MODE_CTRL_OFS, 32'h2);
    idle(20);
    check("sleep_defer", {31'h0, slp}, 32'h0);
    rxf <= 1'h0;
    txf <= 1'h0;
    wait_for(1'h1, 1'h1);
    rdx(csm_pkg::STATE_FLAGS_OFS, 32'h1E, 32'h12, "asleep");
    $display("test sleep done");
    dom <= 1'h1;
    idle(4);
    dom <= 1'h0;
    idle(4);
    rdx(csm_pkg::STATE_FLAGS_OFS, 32'h1A, 32'h1A, "wake_flag");
    bus(1'h1, csm_pkg::STATE_FLAGS_OFS, 32'h0);
    rdx(csm_pkg::STATE_FLAGS_OFS, 32'h1A, 32'h1A, "zero_write");
    bus(1'h1, csm_pkg::STATE_FLAGS_OFS, 32'h18);
    rdx(csm_pkg::STATE_FLAGS_OFS, 32'h1A, 32'h2, "w1c");
    bus(1'h1, csm_pkg::MODE_CTRL_OFS, 32'h22);
    dom <= 1'h1;
    idle(4);
    dom <= 1'h0;
    wait_for(1'h0, 1'h1);
    rdx(csm_pkg::MODE_CTRL_OFS, 32'h22, 32'h20, "auto_clear");
    $display("test flags done");
    txf <= 1'h1;
    bus(1'h1, csm_pkg::MODE_CTRL_OFS, 32'h1);
    idle(20);
    check("init_defer", {31'h0, ini}, 32'h0);
    txf <= 1'h0;
    wait_for(1'h1, 1'h0);
    rdx(csm_pkg::STATE_FLAGS_OFS, 32'h3, 32'h1, "in_init");
    bus(1'h1, csm_pkg::MODE_CTRL_OFS, 32'h0);
    wait_for(1'h0, 1'h0);
    $display("test init done");
    for (k = 0; k < 24; k++) begin
      seed = xs(seed);
      bus(1'h1, csm_pkg::ERR_SRC_OFS, {27'h0, k[3], seed[3:0]});
      err <= {seed[10:8], k[2:0]};
      idle(3);
      err <= '0;
      ef = (seed[10] & seed[2]) | (seed[9] & seed[1]) | (seed[8] & seed[0]) | (k[3] & (k[2:0] != 3'h0) & (k[2:0] != 3'h7));
      rdx(csm_pkg::STATE_FLAGS_OFS, 32'h4, {29'h0, ef, 2'h0}, "err_flag");
      bus(1'h1, csm_pkg::STATE_FLAGS_OFS, 32'h4);
    end
    $display("test errors done");
    results();
  end
endmodule : tb
bind csm_state_flags csm_state_flags_chk u_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_waitrequest_o(avs_waitrequest_o),
  .avs_readdata_o(avs_readdata_o), .link_i(link_i), .sleep_state_o(sleep_state_o), .init_state_o(init_state_o));
`default_nettype wire
